// File: ctu_cfg.svh
// register offsets, field positions and reset values of the charge-time unit
// assumes inclusion by ctu_top and the bench; definitions only
`ifndef CTU_CFG_SVH
`define CTU_CFG_SVH
// =====================================================
// register byte addresses
`define CTU_OFS_CTRL_LOW   12'h000
`define CTU_OFS_CTRL_HIGH  12'h004
`define CTU_OFS_DISCHARGE  12'h008
// =====================================================
// control low fields
`define CTU_B_UNIT_EN      15
`define CTU_B_STOP_IDLE    13
`define CTU_B_DELAY_GEN    12
`define CTU_B_EDGE_PASS    11
`define CTU_B_EDGE_ORDER   10
`define CTU_B_GROUND       9
`define CTU_B_TRIG_OUT     8
`define CTU_TRIM_HI        7
`define CTU_TRIM_LO        2
`define CTU_RANGE_HI       1
`define CTU_RANGE_LO       0
`define CTU_LOW_MASK       16'hbfff
// =====================================================
// control high fields
`define CTU_B_E1_MODE      15
`define CTU_B_E1_POL       14
`define CTU_E1_SRC_HI      13
`define CTU_E1_SRC_LO      10
`define CTU_B_E2_SEEN      9
`define CTU_B_E1_SEEN      8
`define CTU_B_E2_MODE      7
`define CTU_B_E2_POL       6
`define CTU_E2_SRC_HI      5
`define CTU_E2_SRC_LO      2
`define CTU_B_HIGH_RANGE   0
`define CTU_HIGH_MASK      16'hfffd
// =====================================================
// discharge control fields
`define CTU_B_RST_EN       4
`define CTU_DSCH_HI        2
`define CTU_DSCH_LO        0
`define CTU_DSCH_MASK      16'h0017
`define CTU_REG_RESET      16'h0000
`endif

// File: ctu_pkg.sv
// types shared by the charge-time unit files
// assumes ctu_cfg.svh is on the include path
package ctu_pkg;
  typedef logic [15:0] ctu_word_t;
  typedef logic [15:0] ctu_src_t;
  typedef enum logic [2:0] {
    CTU_RANGE_550N = 3'h1,
    CTU_RANGE_LOW  = 3'h2,
    CTU_RANGE_HIGH = 3'h4
  } ctu_rband_e;
  typedef enum logic [2:0] {
    CTU_BUS_IDLE = 3'h1,
    CTU_BUS_WRSP = 3'h2,
    CTU_BUS_RRSP = 3'h4
  } ctu_bus_e;
endpackage

// File: ctu_edge_chan.sv
// one edge channel: pin synchroniser, polarity and level/edge detection
// assumes the source may be asynchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module ctu_edge_chan (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [15:0] src_in,
  input  wire logic [3:0]  src_sel,
  input  wire logic        polarity,
  input  wire logic        edge_mode,
  output logic             event_hit
);
  import ctu_pkg::*;
  typedef struct packed {
    ctu_src_t meta;
    ctu_src_t sync;
    logic     prev;
  } ctu_chan_s;
  ctu_chan_s st_r, st_nxt;
  logic lvl;
  // =====================================================
  // synchronise, select, detect
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = src_in;
    st_nxt.sync = st_r.meta;
    lvl         = st_r.sync[src_sel] ~^ polarity;
    st_nxt.prev = lvl;
    // edge mode needs a transition into the active level
    event_hit   = edge_mode ? (lvl && !st_r.prev) : lvl;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // =====================================================
  // checks
  edge_once_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (edge_mode && event_hit) |=> !(edge_mode && event_hit))
    else $error("one transition reported twice");
endmodule
`default_nettype wire

// File: ctu_top.sv
// charge-time unit control: registers over axi4-lite, edge channels,
// current source steering
// assumes on-chip sources are raw levels; analog parts lie outside
//
// How it works
// - stop_in_idle halts the unit while chip idle is high
// - delay generation on steers current to comparator, else to converter
// - edge_pass_enable clear blocks all edge events
// - edge_order_enable accepts edge 2 only after edge 1
// - source_ground_enable grounds the current source output
// - trigger output driven only while trigger_output_enable is set
// - six-bit current trim is a signed adjustment, zero is nominal
// - range codes decode per high-range bit; 11 and 10 reserved when high
// - high_range_select bit 0 of high register picks high current set
// - polarity bit 1 means rising, 0 falling; bits 14 and 6
// - four-bit edge 2 source decode to sixteen inputs
// - edges set seen bits; software may also write them
// - reset enable lets chosen discharge source clear edge logic
// - three-bit discharge source decode, 101 and 000 disabled
`timescale 1ns/10ps
`default_nettype none
`include "ctu_cfg.svh"
module ctu_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        chip_idle,
  input  wire logic [15:0] first_edge_inputs,
  input  wire logic [15:0] second_edge_inputs,
  input  wire logic [7:0]  discharge_inputs,
  output logic             current_on,
  output logic             route_comparator,
  output logic             route_converter,
  output logic             route_diode,
  output logic             source_ground,
  output logic             trigger_out,
  output logic             delay_gen_on,
  output logic [5:0]       current_trim,
  output ctu_pkg::ctu_rband_e current_band,
  output logic [1:0]       current_step,
  output logic             range_reserved
);
  import ctu_pkg::*;
  // =====================================================
  // state
  typedef struct packed {
    ctu_bus_e  bus;
    ctu_word_t ctl_low;
    ctu_word_t ctl_high;
    ctu_word_t dsch;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        aw_got;
    logic        w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        dmeta_idle;
    logic        idle_s;
    logic [7:0]  dmeta;
    logic [7:0]  dsync;
    logic        curr_on;
    logic        rt_cmp;
    logic        rt_adc;
    logic        rt_diode;
    logic        gnd;
    logic        trig;
    logic        dgen;
    logic [5:0]  trim;
    ctu_rband_e  band;
    logic [1:0]  step;
    logic        rsvd;
  } ctu_top_s;
  ctu_top_s st_r, st_nxt;
  logic       run;
  logic       e1_hit, e2_hit;
  logic       dsch_hit;
  logic       wr_fire;
  logic [15:0] wval;
  logic [15:0] cur;
  logic [15:0] mask;
  logic       e1_seen, e2_seen;
  // =====================================================
  // edge channels
  ctu_edge_chan u_first (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .src_in    (first_edge_inputs),
    .src_sel   (st_r.ctl_high[`CTU_E1_SRC_HI:`CTU_E1_SRC_LO]),
    .polarity  (st_r.ctl_high[`CTU_B_E1_POL]),
    .edge_mode (st_r.ctl_high[`CTU_B_E1_MODE]),
    .event_hit (e1_hit)
  );
  // second_edge_inputs index equals the source code
  ctu_edge_chan u_second (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .src_in    (second_edge_inputs),
    .src_sel   (st_r.ctl_high[`CTU_E2_SRC_HI:`CTU_E2_SRC_LO]),
    .polarity  (st_r.ctl_high[`CTU_B_E2_POL]),
    .edge_mode (st_r.ctl_high[`CTU_B_E2_MODE]),
    .event_hit (e2_hit)
  );
  // =====================================================
  // bus handshakes; one write or one read in flight at a time, responses registered
  assign s_axi_awready = (st_r.bus == CTU_BUS_IDLE) && !st_r.aw_got;
  assign s_axi_wready  = (st_r.bus == CTU_BUS_IDLE) && !st_r.w_got;
  assign s_axi_arready = (st_r.bus == CTU_BUS_IDLE) && !s_axi_awvalid && !s_axi_wvalid
                         && !st_r.aw_got && !st_r.w_got;
  assign s_axi_bvalid  = (st_r.bus == CTU_BUS_WRSP);
  assign s_axi_rvalid  = (st_r.bus == CTU_BUS_RRSP);
  assign s_axi_bresp   = st_r.resp;
  assign s_axi_rresp   = st_r.resp;
  assign s_axi_rdata   = st_r.rdata;
  assign current_on       = st_r.curr_on;
  assign route_comparator = st_r.rt_cmp;
  assign route_converter  = st_r.rt_adc;
  assign route_diode      = st_r.rt_diode;
  assign source_ground    = st_r.gnd;
  assign trigger_out      = st_r.trig;
  assign delay_gen_on     = st_r.dgen;
  assign current_trim     = st_r.trim;
  assign current_band     = st_r.band;
  assign current_step     = st_r.step;
  assign range_reserved   = st_r.rsvd;
  // =====================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    wval   = '0;
    cur    = '0;
    mask   = '0;
    wr_fire = 1'b0;
    // chip idle and discharge sources come from other logic, synchronise anyway
    st_nxt.dmeta_idle = chip_idle;
    st_nxt.idle_s     = st_r.dmeta_idle;
    st_nxt.dmeta      = discharge_inputs;
    st_nxt.dsync      = st_r.dmeta;
    // unit runs when enabled and not held by idle
    run = st_r.ctl_low[`CTU_B_UNIT_EN] && !(st_r.ctl_low[`CTU_B_STOP_IDLE] && st_r.idle_s);
    // discharge source decode, codes 000 and 101 disabled
    case (st_r.dsch[`CTU_DSCH_HI:`CTU_DSCH_LO])
      3'h1:    dsch_hit = st_r.dsync[1];
      3'h2:    dsch_hit = st_r.dsync[2];
      3'h3:    dsch_hit = st_r.dsync[3];
      3'h4:    dsch_hit = st_r.dsync[4];
      3'h6:    dsch_hit = st_r.dsync[6];
      3'h7:    dsch_hit = st_r.dsync[7];
      default: dsch_hit = 1'b0;
    endcase
    // bus capture
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    case (st_r.bus)
      CTU_BUS_IDLE: begin
        if (st_r.aw_got && st_r.w_got) begin
          wr_fire       = 1'b1;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.bus    = CTU_BUS_WRSP;
          st_nxt.resp   = 2'h0;
          case (st_r.awaddr)
            `CTU_OFS_CTRL_LOW:  begin cur = st_r.ctl_low;  mask = `CTU_LOW_MASK;  end
            `CTU_OFS_CTRL_HIGH: begin cur = st_r.ctl_high; mask = `CTU_HIGH_MASK; end
            `CTU_OFS_DISCHARGE: begin cur = st_r.dsch;     mask = `CTU_DSCH_MASK; end
            default:            st_nxt.resp = 2'h2;
          endcase
          wval[7:0]  = st_r.wstrb[0] ? st_r.wdata[7:0]  : cur[7:0];
          wval[15:8] = st_r.wstrb[1] ? st_r.wdata[15:8] : cur[15:8];
          wval       = wval & mask;
        end else if (s_axi_arvalid && s_axi_arready) begin
          st_nxt.bus   = CTU_BUS_RRSP;
          st_nxt.resp  = 2'h0;
          st_nxt.rdata = '0;
          case (s_axi_araddr)
            `CTU_OFS_CTRL_LOW:  st_nxt.rdata = {16'h0000, st_r.ctl_low};
            `CTU_OFS_CTRL_HIGH: st_nxt.rdata = {16'h0000, st_r.ctl_high};
            `CTU_OFS_DISCHARGE: st_nxt.rdata = {16'h0000, st_r.dsch};
            default:            st_nxt.resp  = 2'h2;
          endcase
        end
      end
      CTU_BUS_WRSP: if (s_axi_bready) st_nxt.bus = CTU_BUS_IDLE;
      CTU_BUS_RRSP: if (s_axi_rready) st_nxt.bus = CTU_BUS_IDLE;
      default:      st_nxt.bus = CTU_BUS_IDLE;
    endcase
    if (wr_fire && st_nxt.resp == 2'h0) begin
      case (st_r.awaddr)
        `CTU_OFS_CTRL_LOW:  st_nxt.ctl_low  = wval;
        `CTU_OFS_CTRL_HIGH: st_nxt.ctl_high = wval;   // seen bits writable
        default:            st_nxt.dsch     = wval;
      endcase
    end
    // edge status; software write first, hardware set wins over it
    e1_seen = st_nxt.ctl_high[`CTU_B_E1_SEEN];
    e2_seen = st_nxt.ctl_high[`CTU_B_E2_SEEN];
    if (run && st_r.ctl_low[`CTU_B_EDGE_PASS]) begin
      if (e1_hit) e1_seen = 1'b1;
      // order enforced against the status already held
      if (e2_hit && (!st_r.ctl_low[`CTU_B_EDGE_ORDER] || st_r.ctl_high[`CTU_B_E1_SEEN])) begin
        e2_seen = 1'b1;
      end
    end
    // discharge source clears edge detect state when allowed
    if (run && st_r.dsch[`CTU_B_RST_EN] && dsch_hit) begin
      e1_seen = 1'b0;
      e2_seen = 1'b0;
    end
    st_nxt.ctl_high[`CTU_B_E1_SEEN] = e1_seen;
    st_nxt.ctl_high[`CTU_B_E2_SEEN] = e2_seen;
    // steering outputs
    st_nxt.curr_on  = run && (st_r.ctl_high[`CTU_B_E1_SEEN] ^ st_r.ctl_high[`CTU_B_E2_SEEN]);
    st_nxt.rt_cmp   = run && st_r.ctl_low[`CTU_B_DELAY_GEN];
    st_nxt.rt_adc   = run && !st_r.ctl_low[`CTU_B_DELAY_GEN];
    // equal status bits send the source to the diode path
    st_nxt.rt_diode = run && !st_r.ctl_low[`CTU_B_DELAY_GEN]
                      && (st_r.ctl_high[`CTU_B_E1_SEEN] == st_r.ctl_high[`CTU_B_E2_SEEN]);
    st_nxt.dgen     = run && st_r.ctl_low[`CTU_B_DELAY_GEN];
    st_nxt.gnd      = run && st_r.ctl_low[`CTU_B_GROUND];
    st_nxt.trig     = run && st_r.ctl_low[`CTU_B_TRIG_OUT] && st_r.curr_on;
    // trim passed as two's complement, zero nominal
    st_nxt.trim     = st_r.ctl_low[`CTU_TRIM_HI:`CTU_TRIM_LO];
    st_nxt.step     = st_r.ctl_low[`CTU_RANGE_HI:`CTU_RANGE_LO];
    // range decode
    st_nxt.rsvd = 1'b0;
    if (st_r.ctl_high[`CTU_B_HIGH_RANGE]) begin
      st_nxt.band = CTU_RANGE_HIGH;
      st_nxt.rsvd = st_r.ctl_low[`CTU_RANGE_HI];
    end else if (st_r.ctl_low[`CTU_RANGE_HI]) begin
      st_nxt.band = CTU_RANGE_LOW;
    end else begin
      st_nxt.band = CTU_RANGE_550N;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.bus  <= CTU_BUS_IDLE;
      st_r.band <= CTU_RANGE_550N;
    end else begin
      st_r <= st_nxt;
    end
  end
  // =====================================================
  // checks
  unit_off_quiet_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !st_r.ctl_low[`CTU_B_UNIT_EN] |=> !current_on && !trigger_out && !source_ground)
    else $error("unit disabled but outputs active");
  idle_halt_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctl_low[`CTU_B_STOP_IDLE] && st_r.idle_s) |=> !route_comparator && !route_converter)
    else $error("unit ran during idle stop");
  route_select_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run |=> (route_comparator == $past(st_r.ctl_low[`CTU_B_DELAY_GEN])) && (route_converter != route_comparator))
    else $error("current routing wrong");
  edge_block_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_r.ctl_low[`CTU_B_EDGE_PASS] && !wr_fire && !st_r.ctl_high[`CTU_B_E1_SEEN])
      |=> !st_r.ctl_high[`CTU_B_E1_SEEN])
    else $error("blocked edge set status");
  edge_order_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctl_low[`CTU_B_EDGE_ORDER] && !st_r.ctl_high[`CTU_B_E1_SEEN] && !st_r.ctl_high[`CTU_B_E2_SEEN]
      && !wr_fire) |=> !st_r.ctl_high[`CTU_B_E2_SEEN])
    else $error("edge 2 accepted before edge 1");
  ground_follow_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run && st_r.ctl_low[`CTU_B_GROUND] |=> source_ground)
    else $error("ground not applied");
  trig_gate_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !st_r.ctl_low[`CTU_B_TRIG_OUT] |=> !trigger_out)
    else $error("trigger without enable");
  high_range_a : assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.ctl_high[`CTU_B_HIGH_RANGE] |=> current_band == CTU_RANGE_HIGH)
    else $error("high range not selected");
  edge_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (run && st_r.ctl_low[`CTU_B_EDGE_PASS] && e1_hit && !(st_r.dsch[`CTU_B_RST_EN] && dsch_hit))
      |=> st_r.ctl_high[`CTU_B_E1_SEEN])
    else $error("edge 1 event lost");
  one_hot_on_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run ##1 run |-> current_on == $past(st_r.ctl_high[`CTU_B_E1_SEEN] ^ st_r.ctl_high[`CTU_B_E2_SEEN]))
    else $error("current source state wrong");
  dsch_reset_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (run && st_r.dsch[`CTU_B_RST_EN] && dsch_hit) |=> !st_r.ctl_high[`CTU_B_E1_SEEN] && !st_r.ctl_high[`CTU_B_E2_SEEN])
    else $error("discharge reset ignored");
  delay_gen_a : assert property (@(posedge aclk) disable iff (!aresetn)
    run |=> delay_gen_on == $past(st_r.ctl_low[`CTU_B_DELAY_GEN]))
    else $error("delay generation state wrong");
  idle_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctl_low[`CTU_B_UNIT_EN] && !st_r.ctl_low[`CTU_B_STOP_IDLE]) |=> route_comparator || route_converter)
    else $error("unit stopped without idle stop");
  edge2_block_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_r.ctl_low[`CTU_B_EDGE_PASS] && !wr_fire && !st_r.ctl_high[`CTU_B_E2_SEEN])
      |=> !st_r.ctl_high[`CTU_B_E2_SEEN])
    else $error("blocked edge 2 set status");
  ground_off_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !st_r.ctl_low[`CTU_B_GROUND] |=> !source_ground)
    else $error("ground without enable");
  trim_pass_a : assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> current_trim == $past(st_r.ctl_low[`CTU_TRIM_HI:`CTU_TRIM_LO]))
    else $error("trim not passed");
  range_step_a : assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> current_step == $past(st_r.ctl_low[`CTU_RANGE_HI:`CTU_RANGE_LO]))
    else $error("range code not passed");
  range_rsvd_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctl_high[`CTU_B_HIGH_RANGE] && st_r.ctl_low[`CTU_RANGE_HI]) |=> range_reserved)
    else $error("reserved code not flagged");
  low_band_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (!st_r.ctl_high[`CTU_B_HIGH_RANGE] && st_r.ctl_low[`CTU_RANGE_HI]) |=> current_band == CTU_RANGE_LOW)
    else $error("low current set not chosen");
  edge2_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (run && st_r.ctl_low[`CTU_B_EDGE_PASS] && !st_r.ctl_low[`CTU_B_EDGE_ORDER] && e2_hit
      && !(st_r.dsch[`CTU_B_RST_EN] && dsch_hit)) |=> st_r.ctl_high[`CTU_B_E2_SEEN])
    else $error("edge 2 event lost");
  diode_on_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (run && !st_r.ctl_low[`CTU_B_DELAY_GEN]
      && (st_r.ctl_high[`CTU_B_E1_SEEN] == st_r.ctl_high[`CTU_B_E2_SEEN])) |=> route_diode)
    else $error("diode path not taken");
  diode_off_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r.ctl_high[`CTU_B_E1_SEEN] != st_r.ctl_high[`CTU_B_E2_SEEN]) |=> !route_diode)
    else $error("diode path while source on");
endmodule
`default_nettype wire

// File: ctu_src_model.sv
// on-chip edge sources, idle flag and discharge sources seen by the charge-time unit
// assumes the bench calls its tasks just after a rising edge of aclk
`timescale 1ns/10ps
`default_nettype none
module ctu_src_model (
  input  wire logic        aclk,
  output logic             chip_idle,
  output logic [15:0]      first_edge_inputs,
  output logic [15:0]      second_edge_inputs,
  output logic [7:0]       discharge_inputs
);
  // =====================================================
  // source levels
  // converter stand-in: request bit and channel 24 for a die temperature reading
  logic       conv_request = 1'b0;
  logic [7:0] conv_channel = 8'h00;
  task automatic temp_setup();
    conv_request <= 1'b1;
    conv_channel <= 8'h18;
  endtask
  initial begin
    chip_idle = 1'b0;
    first_edge_inputs = 16'h0000;
    second_edge_inputs = 16'h0000;
    discharge_inputs = 8'h00;
  end
  task automatic drive(input int grp, input int idx, input logic v);
    case (grp)
      0: first_edge_inputs[idx] <= v;
      1: second_edge_inputs[idx] <= v;
      default: discharge_inputs[idx] <= v;
    endcase
  endtask
  // raw levels are asynchronous in spirit; each stands three cycles so the two-stage sync sees it
  task automatic pulse(input int grp, input int idx);
    drive(grp, idx, 1'b1);
    repeat (3) @(posedge aclk);
    drive(grp, idx, 1'b0);
    repeat (3) @(posedge aclk);
  endtask
  task automatic level(input int grp, input int idx, input logic v);
    drive(grp, idx, v);
    repeat (6) @(posedge aclk);
  endtask
  task automatic idle(input logic v);
    chip_idle <= v;
  endtask
endmodule
`default_nettype wire

// File: charge_time_edge_control_bench.sv
// self-checking bench for the charge-time unit control block
// assumes ctu_top, ctu_src_model and ctu_cfg.svh compiled alongside
`timescale 1ns/10ps
`default_nettype none
`include "ctu_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module charge_time_edge_control_bench;
  import ctu_pkg::*;
  localparam logic [15:0] L_EN = 16'h8000;
  localparam logic [15:0] L_PASS = 16'h0800;
  localparam logic [15:0] L_ORD = 16'h0400;
  logic             aclk, aresetn, awvalid, wvalid, arvalid;
  logic [11:0]      awaddr, araddr;
  logic [31:0]      wdata;
  wire logic        awready, wready, bvalid, arready, rvalid, idle;
  wire logic        c_on, r_cmp, r_cnv, r_dio, s_gnd, trig, dgen, rsv;
  wire logic [1:0]  bresp, rresp, step;
  wire logic [31:0] rdata;
  wire logic [15:0] e1_in, e2_in;
  wire logic [7:0]  ds_in;
  wire logic [5:0]  trim;
  ctu_rband_e       band;
  int               err_count, n_compared;
  logic [1:0]       resp;
  logic [15:0]      rd, lo, hi, ds;
  logic [3:0]       s1, s2;
  ctu_src_model src_u (.aclk(aclk), .chip_idle(idle), .first_edge_inputs(e1_in),
    .second_edge_inputs(e2_in), .discharge_inputs(ds_in));
  ctu_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .chip_idle(idle),
    .first_edge_inputs(e1_in), .second_edge_inputs(e2_in), .discharge_inputs(ds_in),
    .current_on(c_on), .route_comparator(r_cmp), .route_converter(r_cnv), .route_diode(r_dio),
    .source_ground(s_gnd), .trigger_out(trig), .delay_gen_on(dgen), .current_trim(trim),
    .current_band(band), .current_step(step), .range_reserved(rsv));
  // =====================================================
  // bus tasks: ready sampled mid-cycle equals its value at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic aok, wok, ad, wd, b;
    ad = 0;
    wd = 0;
    b = 0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      aok = awready;
      wok = wready;
      @(posedge aclk);
      if (aok && !ad) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (wok && !wd) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    while (!b) begin
      @(negedge aclk);
      b = bvalid;
      resp = bresp;
      @(posedge aclk);
    end
  endtask
  task automatic rdr(input logic [11:0] a);
    logic ok;
    ok = 0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!ok) begin
      @(negedge aclk);
      ok = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    ok = 0;
    while (!ok) begin
      @(negedge aclk);
      ok = rvalid;
      rd = rdata[15:0];
      resp = rresp;
      @(posedge aclk);
    end
  endtask
  // outputs are looked at on the falling edge, where they have settled
  task automatic look(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic seen(input logic [1:0] e);
    rdr(`CTU_OFS_CTRL_HIGH);
    `CHK(rd[9:8], e)
  endtask
  function automatic logic [15:0] hw(logic p1, logic [3:0] a, logic [1:0] st, logic p2, logic [3:0] b);
    return {1'b1, p1, a, st, 1'b1, p2, b, 2'b00};
  endfunction
  function automatic ctu_rband_e eband(logic h, logic [1:0] c);
    return h ? CTU_RANGE_HIGH : (c[1] ? CTU_RANGE_LOW : CTU_RANGE_550N);
  endfunction
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // =====================================================
  // clock, watchdog and tests
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    close_out();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {awaddr, araddr, wdata} = '0;
    err_count = 0;
    n_compared = 0;
    void'($urandom(38));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rdr(12'(4 * i));
      `CHK(rd, `CTU_REG_RESET)
    end
    look(0);
    `CHK(band, CTU_RANGE_550N)
    `CHK(c_on, 1'b0)
    @(posedge aclk);
    wr(12'h00c, 16'hffff);
    `CHK(resp, 2'h2)
    rdr(12'h00c);
    `CHK(rd, 16'h0000)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lo = 16'($urandom) & ~L_PASS;
      lo[1:0] = 2'(i);
      lo[7:2] = (i == 0) ? 6'h1f : (i == 1) ? 6'h00 : (i == 2) ? 6'h3f : lo[7:2];
      hi = 16'($urandom);
      hi[0] = i[2];
      ds = 16'($urandom);
      wr(`CTU_OFS_CTRL_LOW, lo);
      wr(`CTU_OFS_CTRL_HIGH, hi);
      wr(`CTU_OFS_DISCHARGE, ds);
      rdr(`CTU_OFS_CTRL_LOW);
      `CHK(rd, lo & `CTU_LOW_MASK)
      rdr(`CTU_OFS_CTRL_HIGH);
      `CHK(rd, hi & `CTU_HIGH_MASK)
      rdr(`CTU_OFS_DISCHARGE);
      `CHK(rd, ds & `CTU_DSCH_MASK)
      look(0);
      `CHK(trim, lo[7:2])
      `CHK(band, eband(hi[0], lo[1:0]))
      `CHK(step, lo[1:0])
      `CHK(rsv, hi[0] & lo[1])
      @(posedge aclk);
    end
    $display("test registers done");
    wr(`CTU_OFS_DISCHARGE, 16'h0000);
    for (int j = 0; j < 8; j++) begin
      wr(`CTU_OFS_CTRL_LOW, L_EN | (16'(j[0]) << 12) | (16'(j[1]) << 9) | 16'h0100);
      wr(`CTU_OFS_CTRL_HIGH, {6'h00, 2'(j >> 1), 8'h00});
      look(2);
      `CHK(c_on, ^j[2:1])
      `CHK(trig, ^j[2:1])
      `CHK(dgen, j[0])
      `CHK(s_gnd, j[1])
      `CHK(r_cmp, j[0])
      `CHK(r_cnv, !j[0])
      `CHK(r_dio, !j[0] & ~^j[2:1])
      @(posedge aclk);
    end
    wr(`CTU_OFS_CTRL_HIGH, 16'h0100);
    wr(`CTU_OFS_CTRL_LOW, L_EN | 16'h2000);
    look(2);
    `CHK(trig, 1'b0)
    @(posedge aclk);
    src_u.idle(1'b1);
    look(6);
    `CHK(c_on, 1'b0)
    @(posedge aclk);
    wr(`CTU_OFS_CTRL_LOW, L_EN);
    look(2);
    `CHK(c_on, 1'b1)
    @(posedge aclk);
    src_u.idle(1'b0);
    wr(`CTU_OFS_CTRL_LOW, 16'h0000);
    look(2);
    `CHK(c_on, 1'b0)
    @(posedge aclk);
    $display("test steering done");
    s1 = 4'($urandom);
    s2 = 4'($urandom);
    // program the channels before edges pass, so the old level setup cannot set status
    wr(`CTU_OFS_CTRL_HIGH, hw(1'b1, s1, 2'b00, 1'b0, s2));
    wr(`CTU_OFS_CTRL_LOW, L_EN | L_PASS);
    src_u.pulse(0, s1);
    seen(2'b01);
    wr(`CTU_OFS_CTRL_HIGH, hw(1'b1, s1, 2'b00, 1'b0, s2));
    src_u.level(1, s2, 1'b1);
    seen(2'b00);
    src_u.level(1, s2, 1'b0);
    seen(2'b10);
    wr(`CTU_OFS_CTRL_LOW, L_EN);
    wr(`CTU_OFS_CTRL_HIGH, hw(1'b1, s1, 2'b00, 1'b1, s2));
    src_u.pulse(0, s1);
    src_u.pulse(1, s2);
    seen(2'b00);
    wr(`CTU_OFS_CTRL_LOW, L_EN | L_PASS | L_ORD);
    src_u.pulse(1, s2);
    seen(2'b00);
    src_u.pulse(0, s1);
    seen(2'b01);
    src_u.pulse(1, s2);
    seen(2'b11);
    $display("test edges done");
    wr(`CTU_OFS_CTRL_LOW, L_EN | L_PASS);
    for (int c = 0; c < 16; c++) begin
      wr(`CTU_OFS_CTRL_HIGH, hw(1'b1, s1, 2'b00, 1'b1, 4'(c)));
      src_u.pulse(1, (c + 1) % 16);
      seen(2'b00);
      src_u.pulse(1, c);
      seen(2'b10);
    end
    for (int c = 0; c < 9; c++) begin
      wr(`CTU_OFS_DISCHARGE, (c < 8) ? 16'(16 + c) : 16'h0004);
      wr(`CTU_OFS_CTRL_HIGH, hw(1'b1, s1, 2'b01, 1'b1, s2));
      src_u.pulse(2, (c < 8) ? c : 4);
      seen((c == 0 || c == 5 || c == 8) ? 2'b01 : 2'b00);
    end
    $display("test sources done");
    wr(`CTU_OFS_DISCHARGE, 16'h0000);
    wr(`CTU_OFS_CTRL_LOW, L_EN | 16'h0003);
    wr(`CTU_OFS_CTRL_HIGH, 16'h0300);
    src_u.temp_setup();
    look(2);
    `CHK(r_dio, 1'b1)
    `CHK(band, CTU_RANGE_LOW)
    `CHK(step, 2'h3)
    $display("test temperature done");
    close_out();
  end
endmodule
`default_nettype wire
